// ===== design/pwmcs_cfg.svh
// Register offsets, field positions, reset values and widths of the PWM bank
`ifndef PWMCS_CFG_SVH
`define PWMCS_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
// Pin function select: register index 0x0D, byte address four times it
`define PWMCS_MODE_INDEX     8'h0D
`define PWMCS_MODE_ADDR      8'h34
`define PWMCS_LEVEL_BASE     8'h00
`define PWMCS_LEVEL_COUNT    4'hA
`define PWMCS_TUNE_LO_ADDR   8'h40
`define PWMCS_TUNE_HI_ADDR   8'h44
`define PWMCS_SEL_HI_ADDR    8'h48
`define PWMCS_PORT_ADDR      8'h4C
`define PWMCS_PINS_ADDR      8'h50

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define PWMCS_MODE_RESET     8'h7F
`define PWMCS_MODE_WIDE_BIT  7
`define PWMCS_PIN_COUNT      7
`define PWMCS_LEVEL_W        6
`define PWMCS_TUNE_W         14
`define PWMCS_DUTY_RESET     8'h00
`define PWMCS_PORT_RESET     7'h00
`define PWMCS_RESP_OKAY      2'h0
`define PWMCS_RESP_SLVERR    2'h2

`endif

// ===== design/pwmcs_pkg.sv
// Types shared by the PWM bank files
`default_nettype none

package pwmcs_pkg;

  // --------------------------------------------------------------------------
  // Register decode result
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWMCS_REG_NONE    = 3'b000,
    PWMCS_REG_LEVEL   = 3'b001,
    PWMCS_REG_MODE    = 3'b010,
    PWMCS_REG_TUNE_LO = 3'b011,
    PWMCS_REG_TUNE_HI = 3'b100,
    PWMCS_REG_SEL_HI  = 3'b101,
    PWMCS_REG_PORT    = 3'b110,
    PWMCS_REG_PINS    = 3'b111
  } pwmcs_reg_t;

  // Pin function select register layout
  typedef struct packed {
    logic       wide;
    logic [6:0] port_sel;
  } pwmcs_mode_t;

endpackage : pwmcs_pkg

`default_nettype wire

// ===== design/pwmcs_channel.sv
// One modulator channel with optional narrow compare width
`timescale 1ns/10ps
`default_nettype none

module pwmcs_channel #(
  parameter int MAX_W    = 14,
  parameter int NARROW_W = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wide,
  input  wire logic [MAX_W-1:0] duty,
  output logic                  pwm_out
);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  if (NARROW_W < 1 || NARROW_W > MAX_W) begin : g_bad_width
    $error("pwmcs_channel: NARROW_W must lie in 1..MAX_W");
  end

  logic [MAX_W-1:0] cnt_reg;
  logic [MAX_W-1:0] cnt_next;
  logic             out_reg;
  logic             out_next;

  // --------------------------------------------------------------------------
  // Counter and compare
  // --------------------------------------------------------------------------
  // Narrow mode wraps every 2**NARROW_W clocks so short periods stay short
  always_comb begin
    cnt_next = cnt_reg + {{(MAX_W-1){1'b0}}, 1'b1};
    if (wide) begin
      out_next = cnt_reg < duty;
    end else begin
      out_next = cnt_reg[NARROW_W-1:0] < duty[NARROW_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign pwm_out = out_reg;

endmodule : pwmcs_channel

`default_nettype wire

// ===== design/pwmcs_top.sv
// Eleven-channel PWM bank with pin function select and AXI4-Lite registers
// Notes on behaviour
// - Eleven independent modulator channels
// - Channels one to ten: six-bit duty, except channel six when wide
// - Tuning channel: fourteen-bit duty, two registers
// - Selectable channel runs six or fourteen bits
// - Mode register steers seven multiplexed pins
// - Select bit 0 modulator, 1 port output
// - Mode resets to 0x7F, pins start ports
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pwmcs_cfg.svh"
`default_nettype none

module pwmcs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [10:0]      channel_out,
  output logic [6:0]       mux_pin_out
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic pwmcs_pkg::pwmcs_reg_t decode(input logic [7:0] addr);
    pwmcs_pkg::pwmcs_reg_t r;
    r = pwmcs_pkg::PWMCS_REG_NONE;
    if (addr[1:0] != 2'h0) begin
      r = pwmcs_pkg::PWMCS_REG_NONE;
    end else if (addr[7:6] == 2'h0 && addr[5:2] < `PWMCS_LEVEL_COUNT) begin
      r = pwmcs_pkg::PWMCS_REG_LEVEL;
    end else if (addr == `PWMCS_MODE_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_MODE;
    end else if (addr == `PWMCS_TUNE_LO_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_TUNE_LO;
    end else if (addr == `PWMCS_TUNE_HI_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_TUNE_HI;
    end else if (addr == `PWMCS_SEL_HI_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_SEL_HI;
    end else if (addr == `PWMCS_PORT_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_PORT;
    end else if (addr == `PWMCS_PINS_ADDR) begin
      r = pwmcs_pkg::PWMCS_REG_PINS;
    end
    return r;
  endfunction : decode

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pwmcs_pkg::pwmcs_mode_t mode_reg,    mode_next;
  logic [5:0]             level_reg    [10];
  logic [5:0]             level_next   [10];
  logic [7:0]             tune_lo_reg, tune_lo_next;
  logic [5:0]             tune_hi_reg, tune_hi_next;
  logic [7:0]             sel_hi_reg,  sel_hi_next;
  logic [6:0]             port_reg,    port_next;
  logic [6:0]             pin_reg,     pin_next;
  logic [10:0]            chan_reg,    chan_next;
  logic [10:0]            raw;
  logic [7:0]             awaddr_reg,  awaddr_next;
  logic [7:0]             wdata_reg,   wdata_next;
  logic                   wstrb_reg,   wstrb_next;
  logic                   aw_have_reg, aw_have_next;
  logic                   w_have_reg,  w_have_next;
  logic                   awready_reg, awready_next;
  logic                   wready_reg,  wready_next;
  logic                   bvalid_reg,  bvalid_next;
  logic [1:0]             bresp_reg,   bresp_next;
  logic                   arready_reg, arready_next;
  logic                   rvalid_reg,  rvalid_next;
  logic [31:0]            rdata_reg,   rdata_next;
  logic [1:0]             rresp_reg,   rresp_next;

  // --------------------------------------------------------------------------
  // Channels
  // --------------------------------------------------------------------------
  // Level channels one to ten sit on raw[0..9], tuning channel on raw[10]
  for (genvar i = 0; i < 10; i++) begin : g_level
    if (i == 5) begin : g_sel
      pwmcs_channel #(.MAX_W(`PWMCS_TUNE_W), .NARROW_W(`PWMCS_LEVEL_W)) u_ch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wide    (mode_reg.wide),
        .duty    ({sel_hi_reg, level_reg[i]}),
        .pwm_out (raw[i])
      );
    end else begin : g_fix
      pwmcs_channel #(.MAX_W(`PWMCS_LEVEL_W), .NARROW_W(`PWMCS_LEVEL_W)) u_ch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wide    (1'b0),
        .duty    (level_reg[i]),
        .pwm_out (raw[i])
      );
    end
  end

  pwmcs_channel #(.MAX_W(`PWMCS_TUNE_W), .NARROW_W(`PWMCS_TUNE_W)) u_tune (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wide    (1'b1),
    .duty    ({tune_hi_reg, tune_lo_reg}),
    .pwm_out (raw[10])
  );

  // --------------------------------------------------------------------------
  // Pin multiplexing
  // --------------------------------------------------------------------------
  always_comb begin
    chan_next = raw;
    // Bit 0 gates channel one; bits 6..1 gate eleven, six, five, four..two
    pin_next[0] = mode_reg.port_sel[0] ? port_reg[0] : raw[0];
    for (int k = 1; k < 6; k++) begin
      pin_next[k] = mode_reg.port_sel[k] ? port_reg[k] : raw[k];
    end
    pin_next[6] = mode_reg.port_sel[6] ? port_reg[6] : raw[10];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_reg <= '0;
      pin_reg  <= `PWMCS_PORT_RESET;
    end else begin
      chan_reg <= chan_next;
      pin_reg  <= pin_next;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave and register writes
  // --------------------------------------------------------------------------
  always_comb begin
    pwmcs_pkg::pwmcs_reg_t wsel;
    pwmcs_pkg::pwmcs_reg_t rsel;
    logic                  do_wr;
    do_wr         = aw_have_reg && w_have_reg && !bvalid_reg;
    wsel          = decode(awaddr_reg);
    rsel          = decode(s_axi_araddr);
    mode_next     = mode_reg;
    level_next    = level_reg;
    tune_lo_next  = tune_lo_reg;
    tune_hi_next  = tune_hi_reg;
    sel_hi_next   = sel_hi_reg;
    port_next     = port_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    aw_have_next  = aw_have_reg;
    w_have_next   = w_have_reg;
    bvalid_next   = bvalid_reg && !s_axi_bready;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg && !s_axi_rready;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next  = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next  = s_axi_wdata[7:0];
      wstrb_next  = s_axi_wstrb[0];
      w_have_next = 1'b1;
    end
    if (do_wr) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wsel == pwmcs_pkg::PWMCS_REG_NONE) ?
                     `PWMCS_RESP_SLVERR : `PWMCS_RESP_OKAY;
      // Only byte lane 0 carries data; other lanes are ignored
      if (wstrb_reg) begin
        case (wsel)
          pwmcs_pkg::PWMCS_REG_LEVEL:
            level_next[awaddr_reg[5:2]] = wdata_reg[5:0];
          pwmcs_pkg::PWMCS_REG_MODE:    mode_next    = wdata_reg;
          pwmcs_pkg::PWMCS_REG_TUNE_LO: tune_lo_next = wdata_reg;
          pwmcs_pkg::PWMCS_REG_TUNE_HI: tune_hi_next = wdata_reg[5:0];
          pwmcs_pkg::PWMCS_REG_SEL_HI:  sel_hi_next  = wdata_reg;
          pwmcs_pkg::PWMCS_REG_PORT:    port_next    = wdata_reg[6:0];
          default: ;
        endcase
      end
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `PWMCS_RESP_OKAY;
      rdata_next  = '0;
      case (rsel)
        pwmcs_pkg::PWMCS_REG_LEVEL:
          rdata_next[5:0] = level_reg[s_axi_araddr[5:2]];
        pwmcs_pkg::PWMCS_REG_MODE:    rdata_next[7:0] = mode_reg;
        pwmcs_pkg::PWMCS_REG_TUNE_LO: rdata_next[7:0] = tune_lo_reg;
        pwmcs_pkg::PWMCS_REG_TUNE_HI: rdata_next[5:0] = tune_hi_reg;
        pwmcs_pkg::PWMCS_REG_SEL_HI:  rdata_next[7:0] = sel_hi_reg;
        pwmcs_pkg::PWMCS_REG_PORT:    rdata_next[6:0] = port_reg;
        pwmcs_pkg::PWMCS_REG_PINS:    rdata_next[6:0] = pin_reg;
        default:                      rresp_next      = `PWMCS_RESP_SLVERR;
      endcase
    end
    // One write and one read in flight; readies drop while a slot is held
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg    <= `PWMCS_MODE_RESET;
      for (int k = 0; k < 10; k++) begin
        level_reg[k] <= 6'(`PWMCS_DUTY_RESET);
      end
      tune_lo_reg <= `PWMCS_DUTY_RESET;
      tune_hi_reg <= '0;
      sel_hi_reg  <= `PWMCS_DUTY_RESET;
      port_reg    <= `PWMCS_PORT_RESET;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PWMCS_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `PWMCS_RESP_OKAY;
    end else begin
      mode_reg    <= mode_next;
      level_reg   <= level_next;
      tune_lo_reg <= tune_lo_next;
      tune_hi_reg <= tune_hi_next;
      sel_hi_reg  <= sel_hi_next;
      port_reg    <= port_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign channel_out   = chan_reg;
  assign mux_pin_out   = pin_reg;

endmodule : pwmcs_top

`default_nettype wire

// ===== tb/pwmcs_chk.sv
// Port checker for the PWM bank
`timescale 1ns/10ps
`default_nettype none

module pwmcs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [10:0] channel_out,
  input wire logic [6:0]  mux_pin_out
);
  // ----------------
  // Sequences
  // ----------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // ----------------
  // Assertions
  // ----------------
  a_reset_outputs:
    assert property ($rose(aresetn) |-> mux_pin_out == 7'h00
      && channel_out == 11'h000) else $error("outputs not idle");
  a_write_answer:
    assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
  a_bresp_hold:
    assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  a_read_answer:
    assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
  a_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
  // Six-bit duty caps a high run at 63 clocks
  a_level_run:
    assert property ($rose(channel_out[0]) |-> ##[1:63] !channel_out[0])
      else $error("level channel high too long");
endmodule : pwmcs_chk

bind pwmcs_top pwmcs_chk pwmcs_chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .channel_out(channel_out),
  .mux_pin_out(mux_pin_out)
);

`default_nettype wire

// ===== tb/test_pwmcs_top.sv
// Self-checking bench for the PWM bank
`timescale 1ns/10ps
`include "pwmcs_cfg.svh"
`default_nettype none

module test_pwmcs_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [10:0] channel_out;
  logic [6:0]  mux_pin_out;
  int          mismatches, n_checks;
  localparam logic [1:0] okay = `PWMCS_RESP_OKAY;
  localparam logic [1:0] slverr = `PWMCS_RESP_SLVERR;
  localparam logic [7:0] mode_a = `PWMCS_MODE_ADDR;

  pwmcs_top pwmcs_top_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .channel_out(channel_out),
    .mux_pin_out(mux_pin_out)
  );

  always #5 aclk = ~aclk;

  // ----------------
  // Common tasks
  // ----------------
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task guard(input int n);
    if (n > 200) begin
      mismatches++;
      final_report;
    end
  endtask : guard

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(e), 32'(bresp));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      guard(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", 32'(r), 32'(rresp));
  endtask : rd

  // Whole periods only, so the phase of the counter does not matter
  task count(input int cyc, b, p, output int hc, hp);
    hc = 0;
    hp = 0;
    repeat (3) @(posedge aclk);
    repeat (cyc) begin
      @(posedge aclk);
      hc += int'(channel_out[b] === 1'b1);
      hp += int'(mux_pin_out[p] === 1'b1);
    end
  endtask : count

  // ----------------
  // Scenarios
  // ----------------
  task t_reset;
    chk("pins", 32'h0, 32'(mux_pin_out));
    chk("chans", 32'h0, 32'(channel_out));
    rd(mode_a, 32'h7F, okay);
    rd(8'h38, 32'h0, slverr);
    wr(8'h35, 32'h0, slverr);
    wstrb <= 4'h0;
    wr(mode_a, 32'h0, okay);
    wstrb <= 4'hF;
    rd(mode_a, 32'h7F, okay);
    $display("test reset done");
  endtask : t_reset

  task t_mode;
    wr(`PWMCS_PORT_ADDR, 32'h7F, okay);
    for (int k = 0; k < `PWMCS_PIN_COUNT; k++) begin
      wr(mode_a, 32'h7F ^ (32'h1 << k), okay);
      repeat (3) @(posedge aclk);
      chk("pins", 32'h7F ^ (32'h1 << k), 32'(mux_pin_out));
      rd(`PWMCS_PINS_ADDR, 32'h7F ^ (32'h1 << k), okay);
    end
    $display("test mode done");
  endtask : t_mode

  task t_duty;
    int hc, hp;
    logic [31:0] d;
    wr(mode_a, 32'h0, okay);
    for (int i = 0; i < `PWMCS_LEVEL_COUNT; i++) begin
      d = (i == 0) ? 32'hFF : 32'(63 - 6 * i);
      wr(8'(4 * i), d, okay);
      rd(8'(4 * i), d & 32'h3F, okay);
      count(64, i, i % 6, hc, hp);
      chk("duty", d & 32'h3F, 32'(hc));
      if (i < 6) chk("pin", d & 32'h3F, 32'(hp));
    end
    $display("test duty done");
  endtask : t_duty

  task t_wide;
    int hc, hp;
    wr(mode_a, 32'h9F, okay);
    wr(`PWMCS_TUNE_LO_ADDR, 32'h05, okay);
    wr(`PWMCS_TUNE_HI_ADDR, 32'hC1, okay);
    rd(`PWMCS_TUNE_HI_ADDR, 32'h01, okay);
    wr(8'h14, 32'h04, okay);
    wr(`PWMCS_SEL_HI_ADDR, 32'h01, okay);
    count(16384, 10, 5, hc, hp);
    chk("tune duty", 32'h105, 32'(hc));
    chk("wide duty", 32'h44, 32'(hp));
    wr(mode_a, 32'h1F, okay);
    rd(mode_a, 32'h1F, okay);
    count(64, 5, 6, hc, hp);
    chk("narrow duty", 32'h04, 32'(hc));
    $display("test wide done");
  endtask : t_wide

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_mode;
    t_duty;
    t_wide;
    final_report;
  end
endmodule : test_pwmcs_top

`default_nettype wire
